/* hdl/mlrf_loop_reset_seq.sv */
// Purpose: reset sequencer of a mainframe on the daisy-chained reset loop
// Assumes: loop pins asynchronous; mainframe_ready and rst on clk
// Notes: only the mainframe itself originates reset; modules do not

`timescale 1ns/10ps
`default_nettype none
`include "mlrf_map.svh"

module mlrf_loop_reset_seq #(
	parameter int unsigned DEGLITCH_CYCLES = `MLRF_DEGLITCH_CYCLES,
	parameter int unsigned INPUT_TO_INTERNAL_CYCLES = `MLRF_INPUT_TO_INTERNAL_CYCLES,
	parameter int unsigned INTERNAL_TO_OUTPUT_CYCLES = `MLRF_INTERNAL_TO_OUTPUT_CYCLES,
	parameter int unsigned RELEASE_CYCLES = `MLRF_RELEASE_CYCLES,
	parameter int unsigned CNT_W = 8
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// mainframe condition
	input wire logic mainframe_ready,
	// loop inputs from the preceding mainframe
	input wire logic source_ready_line_in,
	input wire logic dest_ready_line_in,
	input wire logic loop_reset_in_n,
	// loop outputs toward the next mainframe
	output logic source_ready_line_out,
	output logic dest_ready_line_out,
	output logic loop_reset_out_n,
	// resets inside the mainframe
	output logic backplane_reset,
	output logic bus_reset_n,
	// status
	output mlrf_pkg::mlrf_state_t seq_state,
	output logic glitch_rejected,
	output logic loop_relay_active
);

	import mlrf_pkg::*;

	// ***************************************************************
	// timer loads
	// ***************************************************************
	// a zero count is taken as one cycle so no timed state is skipped
	localparam int unsigned DEGLITCH_LOAD =
		(DEGLITCH_CYCLES > 1) ? DEGLITCH_CYCLES - 1 : 0;
	localparam int unsigned INPUT_TO_INTERNAL_LOAD =
		(INPUT_TO_INTERNAL_CYCLES > 1) ? INPUT_TO_INTERNAL_CYCLES - 1 : 0;
	localparam int unsigned INTERNAL_TO_OUTPUT_LOAD =
		(INTERNAL_TO_OUTPUT_CYCLES > 1) ? INTERNAL_TO_OUTPUT_CYCLES - 1 : 0;
	localparam int unsigned RELEASE_LOAD =
		(RELEASE_CYCLES > 1) ? RELEASE_CYCLES - 1 : 0;

	// ***************************************************************
	// declarations
	// ***************************************************************
	logic [2:0] sync_lines;
	logic loop_ready;
	logic loop_reset_in_active;
	logic loop_quiet;
	mlrf_state_t state;
	mlrf_state_t next_state;
	logic timer_restart;
	logic [CNT_W-1:0] timer_load;
	logic timer_expired;
	logic glitch_event;
	logic next_backplane_reset;
	logic next_loop_reset_out_assert;
	logic next_module_reset_assert;
	logic loop_reset_out_assert;
	logic module_reset_assert;

	// ***************************************************************
	// loop input synchronisation
	// ***************************************************************
	mlrf_sync2 #(
		.WIDTH(3)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in({source_ready_line_in, dest_ready_line_in, loop_reset_in_n}),
		.sync_out(sync_lines)
	);

	// ready means both lines high, reset means the line low
	assign loop_ready = sync_lines[2] & sync_lines[1];
	assign loop_reset_in_active = ~sync_lines[0];
	assign loop_quiet = loop_ready & ~loop_reset_in_active;

	// ***************************************************************
	// state timer
	// ***************************************************************
	// restarts on every state change so each state is timed from entry
	assign timer_restart = (next_state != state);

	always_comb
	begin
		timer_load = '0;
		unique case (next_state)
			MLRF_ST_CHECK,
			MLRF_ST_DEGLITCH:
				timer_load = CNT_W'(DEGLITCH_LOAD);
			MLRF_ST_BP_RESET:
				timer_load = CNT_W'(INPUT_TO_INTERNAL_LOAD);
			MLRF_ST_MOD_RESET:
				timer_load = CNT_W'(INTERNAL_TO_OUTPUT_LOAD);
			MLRF_ST_OUT_RESET:
				timer_load = CNT_W'(RELEASE_LOAD);
			default:
				timer_load = '0;
		endcase
	end

	mlrf_delay_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.restart(timer_restart),
		.load_value(timer_load),
		.expired(timer_expired)
	);

	// ***************************************************************
	// sequence of states
	// ***************************************************************
	// mainframe-only scheme; modules cannot start a loop reset
	always_comb
	begin
		next_state = state;
		if (!mainframe_ready)
		begin
			next_state = MLRF_ST_INIT;
		end
		else
		begin
			unique case (state)
				MLRF_ST_INIT:
					next_state = MLRF_ST_WAIT;
				MLRF_ST_WAIT:
				begin
					// stay while not ready or reset in held
					if (loop_quiet)
						next_state = MLRF_ST_CHECK;
				end
				MLRF_ST_CHECK:
				begin
					// lines re-sampled once the de-glitch time has passed
					if (timer_expired)
					begin
						if (loop_quiet)
						begin
							next_state = MLRF_ST_RUN;
						end
						else
						begin
							next_state = MLRF_ST_WAIT;
						end
					end
				end
				MLRF_ST_RUN:
				begin
					if (loop_reset_in_active)
						next_state = MLRF_ST_DEGLITCH;
				end
				MLRF_ST_DEGLITCH:
				begin
					if (timer_expired)
					begin
						if (loop_reset_in_active)
						begin
							next_state = MLRF_ST_BP_RESET;
						end
						else
						begin
							next_state = MLRF_ST_RUN;
						end
					end
				end
				MLRF_ST_BP_RESET:
				begin
					if (timer_expired)
						next_state = MLRF_ST_MOD_RESET;
				end
				MLRF_ST_MOD_RESET:
				begin
					// outgoing reset lags the input so pulses shrink around the loop
					if (timer_expired)
						next_state = MLRF_ST_OUT_RESET;
				end
				MLRF_ST_OUT_RESET:
				begin
					if (timer_expired)
						next_state = MLRF_ST_RELAY;
				end
				MLRF_ST_RELAY:
				begin
					// input reset passed on until released
					if (!loop_reset_in_active)
						next_state = MLRF_ST_RUN;
				end
				default:
					next_state = MLRF_ST_INIT;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state <= MLRF_ST_INIT;
		else
			state <= next_state;
	end

	// ***************************************************************
	// output decode from the coming state
	// ***************************************************************
	always_comb
	begin
		next_backplane_reset = 1'b0;
		next_loop_reset_out_assert = 1'b0;
		next_module_reset_assert = 1'b0;
		unique case (next_state)
			MLRF_ST_INIT:
			begin
				next_backplane_reset = 1'b1;
				next_loop_reset_out_assert = 1'b1;
				next_module_reset_assert = 1'b1;
			end
			MLRF_ST_WAIT,
			MLRF_ST_CHECK:
				next_module_reset_assert = 1'b1;
			MLRF_ST_BP_RESET:
				next_backplane_reset = 1'b1;
			MLRF_ST_MOD_RESET:
			begin
				next_backplane_reset = 1'b1;
				next_module_reset_assert = 1'b1;
			end
			MLRF_ST_OUT_RESET:
			begin
				next_backplane_reset = 1'b1;
				next_module_reset_assert = 1'b1;
				next_loop_reset_out_assert = 1'b1;
			end
			MLRF_ST_RELAY:
			begin
				next_module_reset_assert = 1'b1;
				next_loop_reset_out_assert = 1'b1;
			end
			default:
			begin
				// run and de-glitch leave every reset released
				next_backplane_reset = 1'b0;
				next_loop_reset_out_assert = 1'b0;
				next_module_reset_assert = 1'b0;
			end
		endcase
	end

	// ***************************************************************
	// registered resets
	// ***************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			backplane_reset <= `MLRF_RST_BACKPLANE;
		else
			backplane_reset <= next_backplane_reset;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			loop_reset_out_assert <= `MLRF_RST_LOOP_OUT_ASSERT;
		else
			loop_reset_out_assert <= next_loop_reset_out_assert;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			module_reset_assert <= `MLRF_RST_MODULE_ASSERT;
		else
			module_reset_assert <= next_module_reset_assert;
	end

	// ***************************************************************
	// registered loop outputs
	// ***************************************************************
	// ready lines follow the backplane reset inverted
	always_ff @(posedge clk)
	begin
		if (rst)
			source_ready_line_out <= ~`MLRF_RST_BACKPLANE;
		else
			source_ready_line_out <= ~next_backplane_reset;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			dest_ready_line_out <= ~`MLRF_RST_BACKPLANE;
		else
			dest_ready_line_out <= ~next_backplane_reset;
	end

	// active-low pins are the asserting flops inverted, glitch free
	assign loop_reset_out_n = ~loop_reset_out_assert;
	assign bus_reset_n = ~module_reset_assert;

	// ***************************************************************
	// glitch detection
	// ***************************************************************
	// a timed check that fails at expiry is a rejected glitch
	always_comb
	begin
		glitch_event = 1'b0;
		if (mainframe_ready && timer_expired)
		begin
			if (state == MLRF_ST_CHECK)
				glitch_event = ~loop_quiet;
			else if (state == MLRF_ST_DEGLITCH)
				glitch_event = ~loop_reset_in_active;
		end
	end

	// ***************************************************************
	// status
	// ***************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			glitch_rejected <= 1'b0;
		else
			glitch_rejected <= glitch_event;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			loop_relay_active <= 1'b0;
		else
			loop_relay_active <= (next_state == MLRF_ST_RELAY);
	end

	assign seq_state = state;

endmodule : mlrf_loop_reset_seq
`default_nettype wire

/* hdl/mlrf_map.svh */
// Purpose: timing counts and reset values of the loop reset sequencer
// Assumes: a single 10 MHz clock, period 100 ns
// Notes: every delay rounds up to whole clock cycles, never below one

`ifndef MLRF_MAP_SVH
`define MLRF_MAP_SVH

// ***************************************************************
// clock and delays
// ***************************************************************
`define MLRF_CLK_PERIOD_NS 100
`define MLRF_DEGLITCH_NS 150
`define MLRF_INPUT_TO_INTERNAL_DELAY_NS 150
`define MLRF_INTERNAL_TO_OUTPUT_DELAY_NS 150
`define MLRF_RELEASE_DELAY_NS 150

`define MLRF_NS_TO_CYCLES(ns) \
	((((ns) + `MLRF_CLK_PERIOD_NS - 1) / `MLRF_CLK_PERIOD_NS) < 1 ? 1 : \
	(((ns) + `MLRF_CLK_PERIOD_NS - 1) / `MLRF_CLK_PERIOD_NS))

`define MLRF_DEGLITCH_CYCLES `MLRF_NS_TO_CYCLES(`MLRF_DEGLITCH_NS)
`define MLRF_INPUT_TO_INTERNAL_CYCLES `MLRF_NS_TO_CYCLES(`MLRF_INPUT_TO_INTERNAL_DELAY_NS)
`define MLRF_INTERNAL_TO_OUTPUT_CYCLES `MLRF_NS_TO_CYCLES(`MLRF_INTERNAL_TO_OUTPUT_DELAY_NS)
`define MLRF_RELEASE_CYCLES `MLRF_NS_TO_CYCLES(`MLRF_RELEASE_DELAY_NS)

// ***************************************************************
// reset values of outputs
// ***************************************************************
`define MLRF_RST_BACKPLANE 1'b1
`define MLRF_RST_LOOP_OUT_ASSERT 1'b1
`define MLRF_RST_MODULE_ASSERT 1'b1
`define MLRF_RST_SYNC 3'h0

`endif

/* hdl/mlrf_pkg.sv */
// Purpose: types shared by the loop reset sequencer files
// Assumes: one-hot state codes
// Notes: none

package mlrf_pkg;

	typedef enum logic [8:0]
	{
		MLRF_ST_INIT = 9'h001,
		MLRF_ST_WAIT = 9'h002,
		MLRF_ST_CHECK = 9'h004,
		MLRF_ST_RUN = 9'h008,
		MLRF_ST_DEGLITCH = 9'h010,
		MLRF_ST_BP_RESET = 9'h020,
		MLRF_ST_MOD_RESET = 9'h040,
		MLRF_ST_OUT_RESET = 9'h080,
		MLRF_ST_RELAY = 9'h100
	} mlrf_state_t;

endpackage : mlrf_pkg

/* hdl/mlrf_sync2.sv */
// Purpose: two flip-flop synchroniser for the loop pins
// Assumes: inputs asynchronous to clk
// Notes: first stage is read only by the second

`timescale 1ns/10ps
`default_nettype none
`include "mlrf_map.svh"

module mlrf_sync2 #(
	parameter int unsigned WIDTH = 3
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// lines
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stage1 <= WIDTH'(`MLRF_RST_SYNC);
			sync_out <= WIDTH'(`MLRF_RST_SYNC);
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : mlrf_sync2
`default_nettype wire

/* hdl/mlrf_delay_timer.sv */
// Purpose: down counter that times each sequencer state
// Assumes: load value is the cycle count minus one
// Notes: expired is a level while the count stands at zero

`timescale 1ns/10ps
`default_nettype none

module mlrf_delay_timer #(
	parameter int unsigned CNT_W = 8
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic restart,
	input wire logic [CNT_W-1:0] load_value,
	// status
	output logic expired
);

	logic [CNT_W-1:0] count;

	always_ff @(posedge clk)
	begin
		if (rst)
			count <= '0;
		else if (restart)
			count <= load_value;
		else if (count != '0)
			count <= count - CNT_W'(1);
	end

	assign expired = (count == '0);

endmodule : mlrf_delay_timer
`default_nettype wire

/* dv/mlrf_loop_reset_seq_sva.sv */
// Purpose: port assertions for the loop reset sequencer
// Assumes: every delay parameter left at 2 cycles
// Notes: bound to all sequencer instances
`timescale 1ns/10ps
`default_nettype none
module mlrf_loop_reset_seq_sva
	import mlrf_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// inputs
	input wire logic mainframe_ready,
	input wire logic source_ready_line_in,
	input wire logic dest_ready_line_in,
	input wire logic loop_reset_in_n,
	// outputs
	input wire logic source_ready_line_out,
	input wire logic dest_ready_line_out,
	input wire logic loop_reset_out_n,
	input wire logic backplane_reset,
	input wire logic bus_reset_n,
	input wire mlrf_pkg::mlrf_state_t seq_state,
	input wire logic glitch_rejected,
	input wire logic loop_relay_active
);
	// ************
	// sequencing
	// ************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || !mainframe_ready);
	sequence s_check_in;
		seq_state != MLRF_ST_CHECK ##1 seq_state == MLRF_ST_CHECK;
	endsequence
	sequence s_dg_in;
		seq_state == MLRF_ST_RUN ##1 seq_state == MLRF_ST_DEGLITCH;
	endsequence
	sequence s_chain;
		(seq_state == MLRF_ST_BP_RESET && backplane_reset && bus_reset_n)[*2]
		##1 (seq_state == MLRF_ST_MOD_RESET && !bus_reset_n && loop_reset_out_n)[*2]
		##1 (seq_state == MLRF_ST_OUT_RESET && !loop_reset_out_n)[*2]
		##1 (seq_state == MLRF_ST_RELAY && !backplane_reset);
	endsequence
	a_init_forced: assert property (disable iff (rst) !mainframe_ready |=>
		seq_state == MLRF_ST_INIT && backplane_reset && !loop_reset_out_n && !bus_reset_n)
		else $error("init not forced");
	a_ready_out_tie: assert property (source_ready_line_out == !backplane_reset
		&& dest_ready_line_out == !backplane_reset) else $error("ready out wrong");
	a_leave_init: assert property (seq_state == MLRF_ST_INIT |=> seq_state == MLRF_ST_WAIT
		&& !backplane_reset && loop_reset_out_n && !bus_reset_n) else $error("init exit wrong");
	a_wait_hold: assert property (seq_state == MLRF_ST_WAIT |->
		!bus_reset_n && loop_reset_out_n) else $error("wait outputs wrong");
	a_check_time: assert property (s_check_in |=> seq_state == MLRF_ST_CHECK
		##1 seq_state inside {MLRF_ST_WAIT, MLRF_ST_RUN}) else $error("check timing");
	a_run_out: assert property (seq_state == MLRF_ST_RUN |-> bus_reset_n
		&& loop_reset_out_n && !backplane_reset) else $error("run outputs wrong");
	a_run_exit: assert property ((seq_state == MLRF_ST_RUN && !loop_reset_in_n)[*3]
		|=> seq_state == MLRF_ST_DEGLITCH) else $error("no deglitch entry");
	a_dg_time: assert property (s_dg_in |=> seq_state == MLRF_ST_DEGLITCH
		##1 seq_state inside {MLRF_ST_RUN, MLRF_ST_BP_RESET}) else $error("deglitch timing");
	a_reset_chain: assert property (seq_state == MLRF_ST_DEGLITCH
		##1 seq_state == MLRF_ST_BP_RESET |-> s_chain) else $error("reset chain wrong");
	a_relay_pass: assert property (seq_state == MLRF_ST_RELAY |-> !loop_reset_out_n
		&& !bus_reset_n && loop_relay_active) else $error("relay outputs wrong");
	a_relay_exit: assert property (seq_state == MLRF_ST_RELAY ##1
		seq_state != MLRF_ST_RELAY |-> seq_state == MLRF_ST_RUN && loop_reset_out_n
		&& bus_reset_n && !loop_relay_active) else $error("relay exit wrong");
	a_glitch_once: assert property (glitch_rejected |->
		seq_state inside {MLRF_ST_WAIT, MLRF_ST_RUN} ##1 !glitch_rejected)
		else $error("glitch pulse wrong");
endmodule : mlrf_loop_reset_seq_sva
bind mlrf_loop_reset_seq mlrf_loop_reset_seq_sva u_sva (.clk(clk), .rst(rst),
	.mainframe_ready(mainframe_ready), .source_ready_line_in(source_ready_line_in),
	.dest_ready_line_in(dest_ready_line_in), .loop_reset_in_n(loop_reset_in_n),
	.source_ready_line_out(source_ready_line_out), .dest_ready_line_out(dest_ready_line_out),
	.loop_reset_out_n(loop_reset_out_n), .backplane_reset(backplane_reset),
	.bus_reset_n(bus_reset_n), .seq_state(seq_state), .glitch_rejected(glitch_rejected),
	.loop_relay_active(loop_relay_active));
`default_nettype wire

/* dv/mlrf_prev_frame.sv */
// Purpose: preceding mainframe on the reset loop
// Assumes: lines change 2 ns after a rising edge
// Notes: driven by tasks called from the bench
`timescale 1ns/10ps
`default_nettype none
module mlrf_prev_frame (
	// clock
	input wire logic clk,
	// loop lines
	output logic source_ready_line,
	output logic dest_ready_line,
	output logic loop_reset_n
);
	// ************
	// line drivers
	// ************
	initial
	begin
		source_ready_line = 1'b1;
		dest_ready_line = 1'b1;
		loop_reset_n = 1'b1;
	end
	task automatic drive(input logic s, input logic d, input logic r);
		@(posedge clk);
		#2;
		source_ready_line = s;
		dest_ready_line = d;
		loop_reset_n = r;
	endtask : drive
	// low for n sampling edges
	task automatic hold_reset(input int n);
		drive(1'b1, 1'b1, 1'b0);
		repeat (n - 1) @(posedge clk);
		drive(1'b1, 1'b1, 1'b1);
	endtask : hold_reset
endmodule : mlrf_prev_frame
`default_nettype wire

/* dv/mlrf_loop_reset_seq_tb.sv */
// Purpose: self-checking bench of the loop reset sequencer
// Assumes: default delay parameters of 2 cycles
// Notes: state and output checks at 2 ns after edges
`timescale 1ns/10ps
`default_nettype none
module mlrf_loop_reset_seq_tb;
	import mlrf_pkg::*;
	logic clk, rst, mainframe_ready;
	logic sri, dri, rin_n, sro, dro, lro_n, bp, brn, gl, rel;
	mlrf_state_t st;
	int err_total, compares, gl_cnt, out_low;
	wire logic [8:0] obs = {4'h0, bp, brn, lro_n, sro, dro};
	mlrf_prev_frame u_prev (.clk(clk), .source_ready_line(sri), .dest_ready_line(dri),
		.loop_reset_n(rin_n));
	mlrf_loop_reset_seq u_dut (.clk(clk), .rst(rst), .mainframe_ready(mainframe_ready),
		.source_ready_line_in(sri), .dest_ready_line_in(dri), .loop_reset_in_n(rin_n),
		.source_ready_line_out(sro), .dest_ready_line_out(dro), .loop_reset_out_n(lro_n),
		.backplane_reset(bp), .bus_reset_n(brn), .seq_state(st), .glitch_rejected(gl),
		.loop_relay_active(rel));
	// ************
	// helpers
	// ************
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(negedge clk)
	begin
		if (gl === 1'b1) gl_cnt++;
		if (lro_n === 1'b0) out_low++;
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	task automatic expect_st(input mlrf_state_t s, input logic [8:0] o);
		for (int i = 0; i < 60 && st !== s; i++) step(1);
		check(st, s);
		check(obs, o);
	endtask : expect_st
	task automatic finish_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	// ************
	// scenarios
	// ************
	task automatic t_startup();
		expect_st(MLRF_ST_WAIT, 9'h007);
		expect_st(MLRF_ST_CHECK, 9'h007);
		expect_st(MLRF_ST_RUN, 9'h00f);
	endtask : t_startup
	task automatic t_loop_reset();
		out_low = 0;
		fork
			u_prev.hold_reset(30);
		join_none
		expect_st(MLRF_ST_DEGLITCH, 9'h00f);
		expect_st(MLRF_ST_BP_RESET, 9'h01c);
		expect_st(MLRF_ST_MOD_RESET, 9'h014);
		expect_st(MLRF_ST_OUT_RESET, 9'h010);
		expect_st(MLRF_ST_RELAY, 9'h003);
		check(9'(rel), 9'h001);
		expect_st(MLRF_ST_RUN, 9'h00f);
		check(9'(out_low), 9'h018);
	endtask : t_loop_reset
	task automatic t_glitch();
		int g;
		g = gl_cnt;
		out_low = 0;
		u_prev.hold_reset(1);
		expect_st(MLRF_ST_DEGLITCH, 9'h00f);
		expect_st(MLRF_ST_RUN, 9'h00f);
		step(4);
		check(9'(gl_cnt - g), 9'h001);
		check(9'(out_low), 9'h000);
	endtask : t_glitch
	task automatic t_not_ready();
		int g;
		mainframe_ready = 1'b0;
		expect_st(MLRF_ST_INIT, 9'h010);
		u_prev.drive(1'b1, 1'b0, 1'b0);
		step(3);
		mainframe_ready = 1'b1;
		expect_st(MLRF_ST_WAIT, 9'h007);
		step(10);
		check(st, MLRF_ST_WAIT);
		check(obs, 9'h007);
		u_prev.drive(1'b1, 1'b0, 1'b1);
		step(8);
		check(st, MLRF_ST_WAIT);
		g = gl_cnt;
		u_prev.drive(1'b1, 1'b1, 1'b1);
		u_prev.drive(1'b1, 1'b0, 1'b1);
		expect_st(MLRF_ST_CHECK, 9'h007);
		expect_st(MLRF_ST_WAIT, 9'h007);
		check(9'(gl), 9'h001);
		step(1);
		check(9'(gl_cnt - g), 9'h001);
		u_prev.drive(1'b1, 1'b1, 1'b1);
		expect_st(MLRF_ST_RUN, 9'h00f);
	endtask : t_not_ready
	// ************
	// main sequence
	// ************
	initial
	begin
		rst = 1'b1;
		mainframe_ready = 1'b1;
		repeat (6) @(posedge clk);
		#2;
		rst = 1'b0;
		t_startup();
		t_loop_reset();
		t_glitch();
		t_not_ready();
		finish_test();
	end
	initial
	begin
		#200000;
		err_total++;
		finish_test();
	end
endmodule : mlrf_loop_reset_seq_tb
`default_nettype wire
